/* shared/hdr_ddr_pkg.sv */
// Constants, types and carriers for the HDR-DDR command decoder
package hdr_ddr_pkg;
    // ========================================================
    // Frame layout
    localparam int         FRAME_BITS   = 20;
    localparam logic [4:0] FRAME_LAST   = 5'h13;
    localparam logic [1:0] PRE_CMD      = 2'h1;
    localparam logic [1:0] PRE_DATA     = 2'h2;
    localparam logic [1:0] PRE_CRC      = 2'h1;
    localparam logic       PAR0_SEED    = 1'b1;
    localparam logic [3:0] CRC_TOKEN    = 4'hC;
    localparam logic [4:0] CRC_INIT     = 5'h1F;
    localparam logic [4:0] CRC_POLY     = 5'h05;
    localparam logic [6:0] CRC_PAD      = 7'h00;
    // ========================================================
    // Mode entry and bus patterns
    localparam logic [2:0] HDR_DDR_MODE     = 3'h0;
    localparam logic [2:0] RESTART_TOGGLES  = 3'h2;
    localparam logic [2:0] EXIT_TOGGLES     = 3'h4;
    // ========================================================
    // Command codes and write data words
    localparam logic [6:0]  WRITE_CMD                 = 7'h3B;
    localparam logic [6:0]  READ_FIELD_16BIT          = 7'h21;
    localparam logic [6:0]  READ_FIELD_20BIT_AND_TEMP = 7'h22;
    localparam logic [6:0]  READ_STATUS_WORD          = 7'h23;
    localparam logic [2:0]  WORDS_SHORT               = 3'h3;
    localparam logic [2:0]  WORDS_LONG                = 3'h5;
    localparam logic [2:0]  WORDS_STATUS              = 3'h1;
    localparam logic [2:0]  WORDS_NONE                = 3'h0;
    localparam logic [15:0] DW_MEAS_MAG               = 16'h0001;
    localparam logic [15:0] DW_MEAS_TEMP              = 16'h0003;
    localparam logic [15:0] DW_CONT_ON                = 16'h0004;
    localparam logic [15:0] DW_DO_SET                 = 16'h0005;
    localparam logic [15:0] DW_CONT_OFF               = 16'h0006;
    localparam logic [15:0] DW_DO_RESET               = 16'h0007;
    // ========================================================
    // Register bus map
    localparam logic [3:0] ADDR_CTRL   = 4'h0;
    localparam logic [3:0] ADDR_STATUS = 4'h4;
    // ========================================================
    // States and carriers
    typedef enum logic [2:0] {
        ST_OFF    = 3'b000,
        ST_CMD    = 3'b001,
        ST_WDATA  = 3'b010,
        ST_WCRC   = 3'b011,
        ST_READ   = 3'b100,
        ST_WAIT   = 3'b101,
        ST_SILENT = 3'b110
    } hdr_state_t;
    typedef struct packed {
        logic [9:0][7:0] fieldData;
        logic [7:0]      primaryStatusReg;
        logic [7:0]      secondaryStatusReg;
    } sensor_regs_t;
    typedef struct packed {
        logic measMag;
        logic measTemp;
        logic doSet;
        logic doReset;
    } action_t;
endpackage : hdr_ddr_pkg

/* verilog/hdr_ddr_command_decoder.sv */
// HDR-DDR command decoder of the magnetic sensor bus target
`timescale 1ns/10ps
`default_nettype none
// Functional notes
// - Enter DDR mode only on the mode-zero entry command; no other HDR mode.
// - Other HDR entry codes: release the data line and wait for exit.
// - Stay in DDR mode across frames until the exit pattern appears.
// - Each frame: two preamble bits, sixteen payload bits, two parity bits.
// - Write command: flag zero, command 3B, then own dynamic address.
// - Data 0001 starts magnetic, 0003 temperature measurement.
// - Data 0004 enables, 0006 disables continuous measurement mode.
// - Data 0005 fires a set pulse, 0007 a reset pulse.
// - Read codes 21 short, 22 long, 23 status are recognised.
// - Short read returns three words, registers 0 to 5, low first.
// - Long read returns five words, registers 0 to 9.
// - Status read returns one word from status registers 18 and 19.
// - Every read ends with an appended CRC word.
// - Status word: primary status byte first, secondary second.
module hdr_ddr_command_decoder #(
    parameter logic [6:0] DEFAULT_DYN_ADDR = 7'h08
) (
    input  wire logic                      clk,
    input  wire logic                      rst_b,
    input  wire logic                      ce,
    input  wire logic [3:0]                avs_address,
    input  wire logic                      avs_read,
    input  wire logic                      avs_write,
    input  wire logic [31:0]               avs_writedata,
    output logic [31:0]                    avs_readdata,
    output logic                           avs_waitrequest,
    input  wire logic                      sclPin,
    input  wire logic                      sdaIn,
    output logic                           sdaOut,
    output logic                           sdaOe,
    input  wire logic                      cccEnter,
    input  wire logic [2:0]                cccMode,
    input  wire hdr_ddr_pkg::sensor_regs_t sensorRegs,
    output hdr_ddr_pkg::action_t           actionPulse,
    output logic                           contMode
);
    import hdr_ddr_pkg::*;

    // ========================================================
    // Helper functions
    // Parity pair over odd and even payload bits
    function automatic logic [1:0] ddrParity(input logic [15:0] p);
        logic odd;
        logic even;
        odd  = 1'b0;
        even = PAR0_SEED;
        for (int i = 0; i < 16; i += 2) begin
            odd  = odd ^ p[i+1];
            even = even ^ p[i];
        end
        return {odd, even};
    endfunction : ddrParity

    function automatic logic [19:0] buildFrame(input logic [1:0] pre, input logic [15:0] pay);
        return {pre, pay, ddrParity(pay)};
    endfunction : buildFrame

    // CRC5 over one word, MSB first
    function automatic logic [4:0] crc5Step(input logic [4:0] c, input logic [15:0] d);
        logic [4:0] r;
        logic       fb;
        r = c;
        for (int i = 15; i >= 0; i--) begin
            fb = r[4] ^ d[i];
            r  = {r[3:0], 1'b0};
            if (fb) begin
                r = r ^ CRC_POLY;
            end
        end
        return r;
    endfunction : crc5Step

    function automatic logic [2:0] wordsFor(input logic [6:0] code);
        case (code)
            READ_FIELD_16BIT:          return WORDS_SHORT;
            READ_FIELD_20BIT_AND_TEMP: return WORDS_LONG;
            READ_STATUS_WORD:          return WORDS_STATUS;
            default:                   return WORDS_NONE;
        endcase
    endfunction : wordsFor

    // Lower-addressed register lands in the upper payload byte
    function automatic logic [15:0] pickWord(input logic [6:0] code, input logic [2:0] idx,
                                             input sensor_regs_t regs);
        logic [3:0] lo;
        lo = {idx, 1'b0};
        if (code == READ_STATUS_WORD) begin
            return {regs.primaryStatusReg, regs.secondaryStatusReg};
        end
        return {regs.fieldData[lo], regs.fieldData[lo + 4'h1]};
    endfunction : pickWord

    // ========================================================
    // Declarations
    logic        sclMeta_reg, sclSync_reg, sclLast_reg;
    logic        sdaMeta_reg, sdaSync_reg, sdaLast_reg;
    logic [2:0]  patCnt_reg;
    logic [4:0]  bitCnt_reg;
    logic [18:0] rxShift_reg;
    hdr_state_t  hdrState_reg;
    logic [19:0] txShift_reg;
    logic [2:0]  wordIdx_reg;
    logic [2:0]  wordsTotal_reg;
    logic [6:0]  rdCode_reg;
    logic [4:0]  crc_reg;
    logic        crcSent_reg;
    action_t     action_reg;
    logic        contMode_reg;
    logic [15:0] lastCmd_reg;
    logic [6:0]  dynAddr_reg;
    logic        ack_reg;
    logic [31:0] readData_reg;

    logic        sclEdge, sclRise, sdaFall;
    logic        exitHit, restartHit;
    logic        receiving, frameDone, cmdDone, dataDone;
    logic [19:0] rxFrame;
    logic [15:0] rxPay;
    logic        parOk, wrOk, rdOk;
    logic [6:0]  rdCode;
    logic        txBoundary;
    logic        dataKnown;

    // ========================================================
    // Pin synchronisers; SCL is sampled, not used as a clock
    always_ff @(posedge clk) begin
        if (!rst_b) begin
            sclMeta_reg <= 1'b1;
            sclSync_reg <= 1'b1;
            sclLast_reg <= 1'b1;
            sdaMeta_reg <= 1'b1;
            sdaSync_reg <= 1'b1;
            sdaLast_reg <= 1'b1;
        end else if (ce) begin
            sclMeta_reg <= sclPin;
            sclSync_reg <= sclMeta_reg;
            sclLast_reg <= sclSync_reg;
            sdaMeta_reg <= sdaIn;
            sdaSync_reg <= sdaMeta_reg;
            sdaLast_reg <= sdaSync_reg;
        end
    end

    // Edge detection after the second stage only
    assign sclEdge = sclSync_reg ^ sclLast_reg;
    assign sclRise = sclSync_reg & ~sclLast_reg;
    assign sdaFall = ~sdaSync_reg & sdaLast_reg;

    // ========================================================
    // Restart and exit patterns: SDA falls while SCL stays low
    always_ff @(posedge clk) begin
        if (!rst_b) begin
            patCnt_reg <= 3'h0;
        end else if (ce) begin
            if (sclSync_reg) begin
                patCnt_reg <= 3'h0;
            end else if (sdaFall && patCnt_reg != EXIT_TOGGLES) begin
                patCnt_reg <= patCnt_reg + 3'h1;
            end
        end
    end

    // Data changes once per SCL phase at most, so two falls mark a pattern
    assign exitHit    = ~sclSync_reg & sdaFall & (patCnt_reg == EXIT_TOGGLES - 3'h1);
    assign restartHit = sclRise & (patCnt_reg >= RESTART_TOGGLES) & (patCnt_reg < EXIT_TOGGLES);

    // ========================================================
    // Frame receiver; every SCL edge carries one bit
    assign receiving = (hdrState_reg == ST_CMD) | (hdrState_reg == ST_WDATA) |
                       (hdrState_reg == ST_WCRC);
    assign rxFrame   = {rxShift_reg, sdaSync_reg};
    assign rxPay     = rxFrame[17:2];
    assign frameDone = sclEdge & (bitCnt_reg == FRAME_LAST) & receiving & ~restartHit;
    assign cmdDone   = frameDone & (hdrState_reg == ST_CMD);
    assign dataDone  = frameDone & (hdrState_reg == ST_WDATA) &
                       (rxFrame[1:0] == ddrParity(rxPay));

    always_ff @(posedge clk) begin
        if (!rst_b) begin
            rxShift_reg <= 19'h00000;
        end else if (ce && sclEdge) begin
            rxShift_reg <= rxFrame[18:0];
        end
    end

    // bit position, shared by receive and transmit
    always_ff @(posedge clk) begin
        if (!rst_b) begin
            bitCnt_reg <= 5'h00;
        end else if (ce) begin
            if (exitHit || restartHit || hdrState_reg == ST_OFF) begin
                bitCnt_reg <= 5'h00;
            end else if (sclEdge && (receiving || hdrState_reg == ST_READ)) begin
                bitCnt_reg <= (bitCnt_reg == FRAME_LAST) ? 5'h00 : bitCnt_reg + 5'h01;
            end
        end
    end

    // ========================================================
    // Command decode; a bad parity pair is treated as a foreign command
    // trusted only through the parity and preamble checks
    assign parOk  = (rxFrame[1:0] == ddrParity(rxPay)) & (rxFrame[19:18] == PRE_CMD);
    assign wrOk   = ~rxPay[15] & (rxPay[14:8] == WRITE_CMD) & (rxPay[7:1] == dynAddr_reg) & parOk;
    assign rdCode = rxPay[7:1];
    assign rdOk   = rxPay[15] & (rxPay[14:8] == dynAddr_reg) & parOk & (wordsFor(rdCode) != WORDS_NONE);

    // ========================================================
    // Mode state machine
    // entry; silent; held until exit
    always_ff @(posedge clk) begin
        if (!rst_b) begin
            hdrState_reg <= ST_OFF;
        end else if (ce) begin
            if (exitHit && hdrState_reg != ST_OFF) begin
                hdrState_reg <= ST_OFF;
            end else if (restartHit && hdrState_reg != ST_OFF && hdrState_reg != ST_SILENT) begin
                hdrState_reg <= ST_CMD;
            end else begin
                case (hdrState_reg)
                    ST_OFF: begin
                        if (cccEnter) begin
                            hdrState_reg <= (cccMode == HDR_DDR_MODE) ? ST_CMD : ST_SILENT;
                        end
                    end
                    ST_CMD: begin
                        if (cmdDone) begin
                            hdrState_reg <= wrOk ? ST_WDATA : (rdOk ? ST_READ : ST_WAIT);
                        end
                    end
                    ST_WDATA: begin
                        if (frameDone) begin
                            hdrState_reg <= ST_WCRC;
                        end
                    end
                    // controller CRC word is consumed, not checked
                    ST_WCRC: begin
                        if (frameDone) begin
                            hdrState_reg <= ST_WAIT;
                        end
                    end
                    ST_READ: begin
                        if (txBoundary && crcSent_reg) begin
                            hdrState_reg <= ST_WAIT;
                        end
                    end
                    ST_WAIT:   hdrState_reg <= ST_WAIT;
                    ST_SILENT: hdrState_reg <= ST_SILENT;
                    default:   hdrState_reg <= ST_OFF;
                endcase
            end
        end
    end

    // ========================================================
    // Read transmitter; bits move on every SCL edge, MSB first
    assign txBoundary = (hdrState_reg == ST_READ) & sclEdge & (bitCnt_reg == FRAME_LAST) & ~restartHit;

    always_ff @(posedge clk) begin
        if (!rst_b) begin
            txShift_reg    <= 20'h00000;
            wordIdx_reg    <= 3'h0;
            wordsTotal_reg <= 3'h0;
            rdCode_reg     <= 7'h00;
            crc_reg        <= CRC_INIT;
            crcSent_reg    <= 1'b0;
        end else if (ce) begin
            if (cmdDone && rdOk) begin
                txShift_reg    <= buildFrame(PRE_DATA, pickWord(rdCode, 3'h0, sensorRegs));
                crc_reg        <= crc5Step(CRC_INIT, pickWord(rdCode, 3'h0, sensorRegs));
                wordIdx_reg    <= 3'h1;
                wordsTotal_reg <= wordsFor(rdCode);
                rdCode_reg     <= rdCode;
                crcSent_reg    <= 1'b0;
            end else if (hdrState_reg == ST_READ && sclEdge) begin
                if (bitCnt_reg != FRAME_LAST) begin
                    txShift_reg <= {txShift_reg[18:0], 1'b0};
                end else if (wordIdx_reg < wordsTotal_reg) begin
                    txShift_reg <= buildFrame(PRE_DATA, pickWord(rdCode_reg, wordIdx_reg, sensorRegs));
                    crc_reg     <= crc5Step(crc_reg, pickWord(rdCode_reg, wordIdx_reg, sensorRegs));
                    wordIdx_reg <= wordIdx_reg + 3'h1;
                end else if (!crcSent_reg) begin
                    txShift_reg <= buildFrame(PRE_CRC, {CRC_TOKEN, crc_reg, CRC_PAD});
                    crcSent_reg <= 1'b1;
                end
            end
        end
    end

    // drive only while a read is being answered
    assign sdaOut = txShift_reg[19];
    assign sdaOe  = (hdrState_reg == ST_READ);

    // ========================================================
    // Write actions; one-cycle pulses and the held continuous mode level to the measurement engine
    assign dataKnown = (rxPay == DW_MEAS_MAG) | (rxPay == DW_MEAS_TEMP) | (rxPay == DW_CONT_ON) |
                       (rxPay == DW_CONT_OFF) | (rxPay == DW_DO_SET) | (rxPay == DW_DO_RESET);

    always_ff @(posedge clk) begin
        if (!rst_b) begin
            action_reg <= '0;
        end else if (ce) begin
            action_reg.measMag  <= dataDone & (rxPay == DW_MEAS_MAG);
            action_reg.measTemp <= dataDone & (rxPay == DW_MEAS_TEMP);
            action_reg.doSet    <= dataDone & (rxPay == DW_DO_SET);
            action_reg.doReset  <= dataDone & (rxPay == DW_DO_RESET);
        end
    end

    always_ff @(posedge clk) begin
        if (!rst_b) begin
            contMode_reg <= 1'b0;
        end else if (ce && dataDone && dataKnown) begin
            if (rxPay == DW_CONT_ON) begin
                contMode_reg <= 1'b1;
            end else if (rxPay == DW_CONT_OFF) begin
                contMode_reg <= 1'b0;
            end
        end
    end

    assign actionPulse = action_reg;
    assign contMode    = contMode_reg;

    // Last command payload, kept for software inspection
    always_ff @(posedge clk) begin
        if (!rst_b) begin
            lastCmd_reg <= 16'h0000;
        end else if (ce && cmdDone) begin
            lastCmd_reg <= rxPay;
        end
    end

    // ========================================================
    // Avalon slave: one wait cycle, then answer
    assign avs_waitrequest = (avs_read | avs_write) & ~ack_reg;
    assign avs_readdata    = readData_reg;

    always_ff @(posedge clk) begin
        if (!rst_b) begin
            ack_reg      <= 1'b0;
            readData_reg <= 32'h00000000;
            dynAddr_reg  <= DEFAULT_DYN_ADDR;
        end else if (ce) begin
            ack_reg <= (avs_read | avs_write) & ~ack_reg;
            if (avs_read && !ack_reg) begin
                case (avs_address)
                    ADDR_CTRL:   readData_reg <= {25'h0000000, dynAddr_reg};
                    ADDR_STATUS: readData_reg <= {lastCmd_reg, 11'h000, sdaOe, contMode_reg, hdrState_reg};
                    default:     readData_reg <= 32'h00000000;
                endcase
            end
            // Address changes mid-read would confuse the decoder; software writes it while idle
            if (avs_write && ack_reg && avs_address == ADDR_CTRL) begin
                dynAddr_reg <= avs_writedata[6:0];
            end
        end
    end

    // ========================================================
    // Checks
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_b || !ce);

    sequence readAccepted;
        cmdDone && rdOk;
    endsequence
    sequence lastWordSent;
        txBoundary && wordIdx_reg == wordsTotal_reg && !crcSent_reg;
    endsequence

    chk_enter_ddr: assert property (
        (hdrState_reg == ST_OFF && cccEnter) |=> ((hdrState_reg == ST_CMD) == ($past(cccMode) == HDR_DDR_MODE)))
        else $error("entry mode decision wrong");
    chk_silent_release: assert property (
        (hdrState_reg == ST_OFF && cccEnter && cccMode != HDR_DDR_MODE) |=> (hdrState_reg == ST_SILENT && !sdaOe))
        else $error("other HDR mode not silent");
    chk_stay_ddr: assert property (
        (hdrState_reg != ST_OFF && !exitHit) |=> hdrState_reg != ST_OFF)
        else $error("left DDR mode without exit");
    chk_frame_length: assert property (
        (txBoundary && !crcSent_reg) |=> (bitCnt_reg == 5'h00 && txShift_reg[1:0] == ddrParity(txShift_reg[17:2])))
        else $error("frame boundary or parity wrong");
    chk_write_filter: assert property (
        (cmdDone && !rxPay[15] && rxPay[14:8] != WRITE_CMD) |=> hdrState_reg == ST_WAIT)
        else $error("unknown write command accepted");
    chk_meas_trigger: assert property (
        (dataDone && rxPay == DW_MEAS_MAG) |=> actionPulse.measMag ##1 !actionPulse.measMag)
        else $error("magnetic trigger not a single pulse");
    chk_cont_mode: assert property (
        (dataDone && (rxPay == DW_CONT_ON || rxPay == DW_CONT_OFF)) |=> contMode == ($past(rxPay) == DW_CONT_ON))
        else $error("continuous mode not updated");
    chk_set_reset: assert property (
        (dataDone && rxPay == DW_DO_SET) |=> (actionPulse.doSet && !actionPulse.doReset))
        else $error("set pulse wrong");
    chk_short_words: assert property (
        (readAccepted and (rdCode == READ_FIELD_16BIT))
        |=> (wordsTotal_reg == WORDS_SHORT && txShift_reg[17:2] == $past({sensorRegs.fieldData[0], sensorRegs.fieldData[1]})))
        else $error("short read first word wrong");
    chk_long_words: assert property (
        (readAccepted and (rdCode == READ_FIELD_20BIT_AND_TEMP)) |=> wordsTotal_reg == WORDS_LONG)
        else $error("long read word count wrong");
    chk_status_word: assert property (
        (readAccepted and (rdCode == READ_STATUS_WORD)) |=> (wordsTotal_reg == WORDS_STATUS &&
        txShift_reg[17:2] == $past({sensorRegs.primaryStatusReg, sensorRegs.secondaryStatusReg})))
        else $error("status word order wrong");
    chk_crc_append: assert property (
        lastWordSent |=> (crcSent_reg && txShift_reg[19:18] == PRE_CRC && txShift_reg[17:14] == CRC_TOKEN))
        else $error("CRC word not appended");
    chk_no_action: assert property (
        (dataDone && !dataKnown) |=> (actionPulse == '0 && $stable(contMode)))
        else $error("unknown data word acted on");
    chk_foreign_read: assert property (
        (cmdDone && rxPay[15] && rxPay[14:8] != dynAddr_reg) |=> (!sdaOe && hdrState_reg == ST_WAIT))
        else $error("foreign read answered");
endmodule : hdr_ddr_command_decoder
`default_nettype wire

/* verif/hdr_ctrl_model.sv */
// Behavioural I3C controller for HDR-DDR traffic
`timescale 1ns/10ps
`default_nettype none
module hdr_ctrl_model (
    output logic      scl,
    output wire logic sda,
    input  wire logic sdaOut,
    input  wire logic sdaOe
);
    logic d = 1'b1;
    logic drv = 1'b1;
    initial scl = 1'b1;
    // ======
    // Released line floats up to the pull-up level
    assign sda = sdaOe ? sdaOut : drv ? d : 1'b1;
    function automatic logic [19:0] frm(input logic [1:0] p, input logic [15:0] w);
        return {p, w, ^(w & 16'hAAAA), ~^(w & 16'h5555)};
    endfunction : frm
    // LSB picked so second parity is one
    function automatic logic [15:0] cmd(input logic [14:0] h);
        return {h, ^({h, 1'b0} & 16'h5554)};
    endfunction : cmd
    task automatic bits(input logic rx, input logic [19:0] fi, output logic [19:0] fo);
        drv = !rx;
        for (int i = 19; i >= 0; i--) begin
            #200 d = fi[i];
            #190 fo[i] = sda;
            #10 scl = ~scl;
        end
    endtask : bits
    // Two falls then SCL rise restart; four falls exit
    task automatic pat(input int n, input logic r);
        drv = 1'b1;
        if (scl) #200 scl = 1'b0;
        repeat (n) begin
            #200 d = 1'b1;
            #200 d = 1'b0;
        end
        #200 scl = r;
    endtask : pat
endmodule : hdr_ctrl_model
`default_nettype wire

/* verif/i3c_hdr_ddr_command_decoder_tb.sv */
// Self-checking bench of the HDR-DDR command decoder
`timescale 1ns/10ps
`default_nettype none
`define CHK(n, e, g) begin checksDone++; if ((g) !== (e)) begin nFail++; $display("wrong value %s expected %0h seen %0h", n, e, g); end end
module i3c_hdr_ddr_command_decoder_tb;
    import hdr_ddr_pkg::*;
    localparam logic [6:0] DYN = 7'h08;
    logic clk = 1'b0, rst_b = 1'b0, ce = 1'b1, rd = 1'b0, wr = 1'b0, ccc = 1'b0;
    logic [3:0] ad = 4'h0;
    logic [2:0] mode = 3'h0;
    logic [31:0] rdata;
    logic wreq, scl, sda, sdaOut, sdaOe, contMode;
    sensor_regs_t regs = {80'h99887766554433221100, 8'hA5, 8'h3C};
    action_t act, last;
    int nFail = 0, checksDone = 0, nAct = 0;
    hdr_ddr_command_decoder #(.DEFAULT_DYN_ADDR(DYN)) dut (.clk(clk), .rst_b(rst_b), .ce(ce), .avs_address(ad),
        .avs_read(rd), .avs_write(wr), .avs_writedata(32'hFFFFFFFF), .avs_readdata(rdata), .avs_waitrequest(wreq),
        .sclPin(scl), .sdaIn(sda), .sdaOut(sdaOut), .sdaOe(sdaOe), .cccEnter(ccc), .cccMode(mode),
        .sensorRegs(regs), .actionPulse(act), .contMode(contMode));
    hdr_ctrl_model ctrl (.scl(scl), .sda(sda), .sdaOut(sdaOut), .sdaOe(sdaOe));
    initial forever #50 clk = ~clk;
    // Pulses last one cycle, so keep the latest
    always @(posedge clk) begin
        if (|act) nAct <= nAct + 1;
        if (|act) last <= act;
    end
    task automatic bus(input logic w, input logic [3:0] a, output logic [31:0] r);
        int n = 0;
        @(posedge clk);
        ad <= a;
        wr <= w;
        rd <= !w;
        do @(posedge clk); while (wreq !== 1'b0 && ++n < 50);
        // A slave that never answers counts as a mismatch
        if (n >= 50) nFail++;
        r = rdata;
        wr <= 1'b0;
        rd <= 1'b0;
    endtask : bus
    function automatic logic [4:0] crc(input logic [4:0] c, input logic [15:0] d);
        for (int i = 15; i >= 0; i--) c = {c[3:0], 1'b0} ^ (c[4] ^ d[i] ? CRC_POLY : 5'h00);
        return c;
    endfunction : crc
    task automatic enter(input logic [2:0] m);
        // SCL must rise after the exit pattern, or the fall count sticks and hides the next restart
        ctrl.pat(4, 1'b1);
        repeat (4) @(posedge clk);
        mode <= m;
        ccc <= 1'b1;
        @(posedge clk);
        ccc <= 1'b0;
    endtask : enter
    task automatic go(input logic [14:0] h);
        logic [19:0] f;
        ctrl.pat(2, 1'b1);
        ctrl.bits(1'b0, ctrl.frm(PRE_CMD, ctrl.cmd(h)), f);
    endtask : go
    // Every write data word; the last uses a foreign command
    task automatic writes;
        logic [15:0] w [8] = '{16'h0001, 16'h0003, 16'h0004, 16'h0005, 16'h0006, 16'h0007, 16'h0002, 16'h0004};
        logic [3:0] pe [8] = '{4'h8, 4'h4, 4'h0, 4'h2, 4'h0, 4'h1, 4'h0, 4'h0};
        logic [19:0] f;
        int n0;
        for (int i = 0; i < 8; i++) begin
            n0 = nAct;
            go({1'b0, i == 7 ? 7'h3A : WRITE_CMD, DYN});
            ctrl.bits(1'b0, ctrl.frm(PRE_DATA, w[i]), f);
            ctrl.bits(1'b0, ctrl.frm(PRE_CRC, {CRC_TOKEN, crc(CRC_INIT, w[i]), CRC_PAD}), f);
            repeat (4) @(posedge clk);
            `CHK("action", pe[i], nAct != n0 ? last : 4'h0)
            `CHK("contMode", i == 2 || i == 3, contMode)
        end
    endtask : writes
    // Codes 21, 22, 23 in turn, each closed by its check word
    task automatic reads;
        logic [19:0] f;
        logic [15:0] v;
        logic [4:0] c;
        int cnt [3] = '{3, 5, 1};
        for (int k = 0; k < 3; k++) begin
            c = CRC_INIT;
            go({1'b1, DYN, READ_FIELD_16BIT + 7'(k)});
            for (int j = 0; j < cnt[k]; j++) begin
                v = k == 2 ? 16'hA53C : {regs.fieldData[2 * j], regs.fieldData[2 * j + 1]};
                c = crc(c, v);
                ctrl.bits(1'b1, 20'h0, f);
                `CHK("reply", ctrl.frm(PRE_DATA, v), f)
            end
            ctrl.bits(1'b1, 20'h0, f);
            `CHK("crc", ctrl.frm(PRE_CRC, {CRC_TOKEN, c, CRC_PAD}), f)
        end
    endtask : reads
    // Foreign address, unknown code, then unsupported entry mode
    task automatic quiet;
        logic [19:0] f;
        logic [31:0] r;
        for (int k = 0; k < 3; k++) begin
            if (k == 2) enter(3'h2);
            go({1'b1, k == 0 ? 7'h09 : DYN, k == 1 ? 7'h24 : READ_STATUS_WORD});
            ctrl.bits(1'b1, 20'h0, f);
            `CHK("quiet", 20'hFFFFF, f)
        end
        bus(1'b0, ADDR_STATUS, r);
        `CHK("silent", 3'h6, r[2:0])
    endtask : quiet
    task automatic closeOut;
        if (nFail == 0 && checksDone > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask : closeOut
    initial begin
        logic [31:0] r;
        repeat (5) @(posedge clk);
        rst_b <= 1'b1;
        bus(1'b1, 4'h8, r);
        bus(1'b0, ADDR_CTRL, r);
        `CHK("ctrl", 32'h8, r)
        bus(1'b0, 4'h8, r);
        `CHK("unmapped", 32'h0, r)
        enter(HDR_DDR_MODE);
        bus(1'b0, ADDR_STATUS, r);
        `CHK("state", 3'h1, r[2:0])
        writes;
        reads;
        quiet;
        closeOut;
    end
    // Whole run needs about 0.4 ms
    initial begin
        #3000000;
        nFail++;
        closeOut;
    end
endmodule : i3c_hdr_ddr_command_decoder_tb
`default_nettype wire
